// >>> hw/cfs_pkg.sv
// constants for the constant frequency selector
package cfs_pkg;
  localparam int CFS_SEL_W = 5;
  localparam int CFS_DI_W = 6;
  localparam int CFS_STAT_W = 3;
  // +-500.00 hz in hundredths needs 17 signed bits
  localparam int CFS_FREQ_W = 17;
  localparam int CFS_NUM_PRESET = 7;
  localparam int CFS_IDX_W = 3;
  // selector codes
  localparam logic [4:0] CFS_SRC_FALSE = 5'h00;
  localparam logic [4:0] CFS_SRC_TRUE = 5'h01;
  localparam logic [4:0] CFS_SRC_DI_FIRST = 5'h02;
  localparam logic [4:0] CFS_SRC_DI_LAST = 5'h07;
  localparam logic [4:0] CFS_SRC_TF_FIRST = 5'h12;
  localparam logic [4:0] CFS_SRC_TF_LAST = 5'h14;
  localparam logic [4:0] CFS_SRC_SV_FIRST = 5'h18;
  localparam logic [4:0] CFS_SRC_SV_LAST = 5'h1a;
  // reset selections: third and fourth digital input, constant false on selector three
  localparam logic [4:0] CFS_SEL1_RST = 5'h04;
  localparam logic [4:0] CFS_SEL2_RST = 5'h05;
  localparam logic [4:0] CFS_SEL3_RST = 5'h00;
  localparam logic CFS_MODE_RST = 1'b0;
  // frequency limit in hundredths of a hertz
  localparam logic signed [CFS_FREQ_W-1:0] CFS_FREQ_MAX = 17'sh0c350;
  localparam logic signed [CFS_FREQ_W-1:0] CFS_FREQ_MIN = -17'sh0c350;
  localparam logic [2:0] CFS_IDX_NONE = 3'h0;
  localparam logic [CFS_FREQ_W-1:0] CFS_FREQ_ZERO = 17'h00000;
endpackage

// >>> hw/cfs_selector.sv
// constant frequency selector top: source choice, mode decode, preset output
`timescale 1ns/1ns
module cfs_selector import cfs_pkg::*; #(
  parameter int FREQ_W = CFS_FREQ_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfgWe,
  input wire logic cfgPacked,
  input wire logic [CFS_SEL_W-1:0] cfgSel1,
  input wire logic [CFS_SEL_W-1:0] cfgSel2,
  input wire logic [CFS_SEL_W-1:0] cfgSel3,
  input wire logic presetWe,
  input wire logic [CFS_IDX_W-1:0] presetIdx,
  input wire logic signed [FREQ_W-1:0] presetVal,
  input wire logic [CFS_DI_W-1:0] diStatus,
  input wire logic [CFS_STAT_W-1:0] timedStatus,
  input wire logic [CFS_STAT_W-1:0] supStatus,
  output logic packedMode,
  output logic [CFS_SEL_W-1:0] sel1,
  output logic [CFS_SEL_W-1:0] sel2,
  output logic [CFS_SEL_W-1:0] sel3,
  output logic [CFS_IDX_W-1:0] activeIdx,
  output logic freqActive,
  output logic signed [FREQ_W-1:0] freqRef
);
  logic packed_r, packed_nxt;
  logic [CFS_SEL_W-1:0] sel_r [3];
  logic [CFS_SEL_W-1:0] sel_nxt [3];
  logic signed [FREQ_W-1:0] preset_r [CFS_NUM_PRESET];
  logic signed [FREQ_W-1:0] preset_nxt [CFS_NUM_PRESET];
  logic [2:0] src;
  logic [CFS_IDX_W-1:0] idx;
  logic [CFS_IDX_W-1:0] idx_r;
  logic signed [FREQ_W-1:0] freq_r, freq_nxt;
  logic signed [FREQ_W-1:0] clampVal;

  // configuration registers
  always_comb begin
    packed_nxt = packed_r;
    sel_nxt[0] = sel_r[0];
    sel_nxt[1] = sel_r[1];
    sel_nxt[2] = sel_r[2];
    if (cfgWe) begin
      packed_nxt = cfgPacked;
      sel_nxt[0] = cfgSel1;
      sel_nxt[1] = cfgSel2;
      sel_nxt[2] = cfgSel3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packed_r <= CFS_MODE_RST;
      sel_r[0] <= CFS_SEL1_RST;
      sel_r[1] <= CFS_SEL2_RST;
      sel_r[2] <= CFS_SEL3_RST;
    end else begin
      packed_r <= packed_nxt;
      sel_r[0] <= sel_nxt[0];
      sel_r[1] <= sel_nxt[1];
      sel_r[2] <= sel_nxt[2];
    end
  end

  // clamp written preset into the legal range
  always_comb begin
    clampVal = presetVal;
    if (presetVal > FREQ_W'(CFS_FREQ_MAX)) begin
      clampVal = FREQ_W'(CFS_FREQ_MAX);
    end else if (presetVal < FREQ_W'(CFS_FREQ_MIN)) begin
      clampVal = FREQ_W'(CFS_FREQ_MIN);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gSrc
      cfs_source_mux uMux (
        .sel(sel_r[g]),
        .diStatus(diStatus),
        .timedStatus(timedStatus),
        .supStatus(supStatus),
        .srcOut(src[g])
      );
    end
    for (g = 0; g < CFS_NUM_PRESET; g++) begin : gPre
      always_comb begin
        preset_nxt[g] = preset_r[g];
        if (presetWe && presetIdx == CFS_IDX_W'(g + 1)) begin
          preset_nxt[g] = clampVal;
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          preset_r[g] <= FREQ_W'(CFS_FREQ_ZERO);
        end else begin
          preset_r[g] <= preset_nxt[g];
        end
      end
    end
  endgenerate

  // preset index decode; highest-numbered preset wins in separate mode
  always_comb begin
    idx = CFS_IDX_NONE;
    if (packed_r) begin
      idx = src;
    end else if (src[2]) begin
      idx = 3'h3;
    end else if (src[1]) begin
      idx = 3'h2;
    end else if (src[0]) begin
      idx = 3'h1;
    end
  end

  always_comb begin
    freq_nxt = FREQ_W'(CFS_FREQ_ZERO);
    if (idx != CFS_IDX_NONE) begin
      freq_nxt = preset_r[3'(idx - 3'h1)];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_r <= CFS_IDX_NONE;
      freq_r <= FREQ_W'(CFS_FREQ_ZERO);
    end else begin
      idx_r <= idx;
      freq_r <= freq_nxt;
    end
  end

  assign packedMode = packed_r;
  assign sel1 = sel_r[0];
  assign sel2 = sel_r[1];
  assign sel3 = sel_r[2];
  assign activeIdx = idx_r;
  assign freqActive = (idx_r != CFS_IDX_NONE);
  assign freqRef = freq_r;

  sep_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!packed_r && src == 3'b001) |=> activeIdx == 3'h1)
    else $error("preset one not active");
  sep_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!packed_r && src[1] && !src[2]) |=> activeIdx == 3'h2)
    else $error("preset two not active");
  sep_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!packed_r && src[2]) |=> activeIdx == 3'h3)
    else $error("preset three not active");
  packed_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    packed_r |=> activeIdx == $past(src))
    else $error("packed code mismatch");
  di_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[0] >= CFS_SRC_DI_FIRST && sel_r[0] <= CFS_SRC_DI_LAST)
    |-> src[0] == diStatus[3'(sel_r[0] - CFS_SRC_DI_FIRST)])
    else $error("digital input routing wrong");
  tf_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    sel_r[1] == CFS_SRC_TF_FIRST |-> src[1] == timedStatus[0])
    else $error("timed routing wrong");
  sv_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    sel_r[2] == CFS_SRC_SV_LAST |-> src[2] == supStatus[2])
    else $error("supervision routing wrong");
  const_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[0] != CFS_SRC_TRUE || src[0]) && (sel_r[1] != CFS_SRC_FALSE || !src[1]))
    else $error("constant source wrong");
  reset_sel_a: assert property (@(posedge clk)
    !rst_n |=> sel1 == CFS_SEL1_RST && sel2 == CFS_SEL2_RST)
    else $error("reset selection wrong");
  freq_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    freqRef <= FREQ_W'(CFS_FREQ_MAX) && freqRef >= FREQ_W'(CFS_FREQ_MIN))
    else $error("frequency out of range");
  freq_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (idx != CFS_IDX_NONE) |=> freqRef == $past(preset_r[3'(idx - 3'h1)]))
    else $error("wrong preset frequency");
  sep_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!packed_r && src == 3'b000) |=> !freqActive)
    else $error("preset active with no source");
  none_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (idx == CFS_IDX_NONE) |=> freqRef == FREQ_W'(CFS_FREQ_ZERO))
    else $error("frequency not zero with no preset");
  cfg_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfgWe |=> packedMode == $past(cfgPacked) && sel1 == $past(cfgSel1)
      && sel2 == $past(cfgSel2) && sel3 == $past(cfgSel3))
    else $error("configuration not loaded");
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cfgWe |=> packedMode == $past(packed_r) && sel1 == $past(sel_r[0])
      && sel2 == $past(sel_r[1]) && sel3 == $past(sel_r[2]))
    else $error("configuration changed without write");
  tf_route_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[1] >= CFS_SRC_TF_FIRST && sel_r[1] <= CFS_SRC_TF_LAST)
    |-> src[1] == timedStatus[2'(sel_r[1] - CFS_SRC_TF_FIRST)])
    else $error("timed routing wrong on selector two");
  sv_route_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[2] >= CFS_SRC_SV_FIRST && sel_r[2] <= CFS_SRC_SV_LAST)
    |-> src[2] == supStatus[2'(sel_r[2] - CFS_SRC_SV_FIRST)])
    else $error("supervision routing wrong on selector three");
  di_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[0] > CFS_SRC_DI_LAST && sel_r[0] < CFS_SRC_TF_FIRST) |-> !src[0])
    else $error("unlisted code not false on selector one");
  tf_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[1] > CFS_SRC_TF_LAST && sel_r[1] < CFS_SRC_SV_FIRST) |-> !src[1])
    else $error("unlisted code not false on selector two");
  sv_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_r[2] > CFS_SRC_SV_LAST) |-> !src[2])
    else $error("unlisted code not false on selector three");
  clamp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (presetWe && presetIdx != CFS_IDX_NONE && presetVal > FREQ_W'(CFS_FREQ_MAX))
    |=> preset_r[3'($past(presetIdx) - 3'h1)] == FREQ_W'(CFS_FREQ_MAX))
    else $error("high preset not clamped");
  clamp_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (presetWe && presetIdx != CFS_IDX_NONE && presetVal < FREQ_W'(CFS_FREQ_MIN))
    |=> preset_r[3'($past(presetIdx) - 3'h1)] == FREQ_W'(CFS_FREQ_MIN))
    else $error("low preset not clamped");

  sep_cov_c: cover property (@(posedge clk) !packed_r && freqActive);
  packed_cov_c: cover property (@(posedge clk) packed_r && activeIdx == 3'h7);
  none_cov_c: cover property (@(posedge clk) packed_r && !freqActive);
  write_cov_c: cover property (@(posedge clk) presetWe && presetVal > FREQ_W'(CFS_FREQ_MAX));
  low_cov_c: cover property (@(posedge clk) presetWe && presetVal < FREQ_W'(CFS_FREQ_MIN));
endmodule

// >>> hw/cfs_source_mux.sv
// one selector: picks a boolean source from its code
`timescale 1ns/1ns
module cfs_source_mux import cfs_pkg::*; (
  input wire logic [CFS_SEL_W-1:0] sel,
  input wire logic [CFS_DI_W-1:0] diStatus,
  input wire logic [CFS_STAT_W-1:0] timedStatus,
  input wire logic [CFS_STAT_W-1:0] supStatus,
  output logic srcOut
);
  always_comb begin
    srcOut = 1'b0;
    if (sel == CFS_SRC_TRUE) begin
      srcOut = 1'b1;
    end else if (sel >= CFS_SRC_DI_FIRST && sel <= CFS_SRC_DI_LAST) begin
      srcOut = diStatus[3'(sel - CFS_SRC_DI_FIRST)];
    end else if (sel >= CFS_SRC_TF_FIRST && sel <= CFS_SRC_TF_LAST) begin
      srcOut = timedStatus[2'(sel - CFS_SRC_TF_FIRST)];
    end else if (sel >= CFS_SRC_SV_FIRST && sel <= CFS_SRC_SV_LAST) begin
      srcOut = supStatus[2'(sel - CFS_SRC_SV_FIRST)];
    end
  end
endmodule

// >>> test/constant_frequency_selector_tb.sv
// self-checking bench for the constant frequency selector
`timescale 1ns/1ns
module constant_frequency_selector_tb;
  import cfs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfgWe = 1'b0, cfgPacked = 1'b0, presetWe = 1'b0;
  logic [4:0] cfgSel1 = 5'h00, cfgSel2 = 5'h00, cfgSel3 = 5'h00;
  logic [2:0] presetIdx = 3'h0, activeIdx;
  logic signed [16:0] presetVal = 17'sh00000, freqRef;
  logic [5:0] diStatus = 6'h00;
  logic [2:0] timedStatus = 3'h0, supStatus = 3'h0;
  logic packedMode, freqActive;
  logic [4:0] sel1, sel2, sel3;
  logic [16:0] pv [8];
  int fails = 0;
  int compares = 0;
  always #4 clk = ~clk;
  cfs_selector i_cfs_selector (.clk(clk), .rst_n(rst_n), .cfgWe(cfgWe), .cfgPacked(cfgPacked),
    .cfgSel1(cfgSel1), .cfgSel2(cfgSel2), .cfgSel3(cfgSel3), .presetWe(presetWe),
    .presetIdx(presetIdx), .presetVal(presetVal), .diStatus(diStatus),
    .timedStatus(timedStatus), .supStatus(supStatus), .packedMode(packedMode),
    .sel1(sel1), .sel2(sel2), .sel3(sel3), .activeIdx(activeIdx),
    .freqActive(freqActive), .freqRef(freqRef));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic stat(input logic [5:0] di, input logic [2:0] tf, input logic [2:0] sv);
    @(posedge clk);
    diStatus <= di;
    timedStatus <= tf;
    supStatus <= sv;
  endtask
  task automatic cfg(input logic pk, input logic [4:0] s1, s2, s3);
    @(posedge clk);
    cfgWe <= 1'b1;
    cfgPacked <= pk;
    cfgSel1 <= s1;
    cfgSel2 <= s2;
    cfgSel3 <= s3;
    @(posedge clk);
    cfgWe <= 1'b0;
    settle();
  endtask
  task automatic want(input logic [2:0] idx);
    chk({14'h0, activeIdx}, {14'h0, idx});
    chk(freqRef, pv[idx]);
    chk({16'h0, freqActive}, {16'h0, idx != 3'h0});
  endtask
  task automatic rst_chk;
    chk({12'h0, sel1}, {12'h0, CFS_SEL1_RST});
    chk({12'h0, sel2}, {12'h0, CFS_SEL2_RST});
    chk({12'h0, sel3}, {12'h0, CFS_SEL3_RST});
    chk({16'h0, packedMode}, {16'h0, CFS_MODE_RST});
    want(3'h0);
  endtask
  task automatic test_presets;
    // preset six and seven are written out of range and must come back clamped
    for (int i = 1; i < 8; i++) begin
      @(posedge clk);
      presetWe <= 1'b1;
      presetIdx <= 3'(i);
      presetVal <= (i == 7) ? 17'sh0ffff : (i == 6) ? 17'sh10000 : 17'(i * 100);
      pv[i] = (i == 7) ? CFS_FREQ_MAX : (i == 6) ? CFS_FREQ_MIN : 17'(i * 100);
    end
    @(posedge clk);
    presetIdx <= 3'h0;
    presetVal <= 17'sh01234;
    @(posedge clk);
    presetWe <= 1'b0;
  endtask
  task automatic test_separate;
    cfg(1'b0, 5'h01, 5'h00, 5'h00);
    want(3'h1);
    cfg(1'b0, 5'h01, 5'h01, 5'h00);
    want(3'h2);
    cfg(1'b0, 5'h01, 5'h01, 5'h01);
    want(3'h3);
    cfg(1'b0, 5'h00, 5'h00, 5'h00);
    want(3'h0);
  endtask
  task automatic test_routing;
    for (int i = 0; i < 6; i++) begin
      stat(6'h01 << i, 3'h0, 3'h0);
      cfg(1'b0, 5'(2 + i), 5'h00, 5'h00);
      want(3'h1);
      stat(~(6'h01 << i), 3'h0, 3'h0);
      settle();
      want(3'h0);
    end
    for (int i = 0; i < 3; i++) begin
      stat(6'h00, 3'h1 << i, 3'h0);
      cfg(1'b0, 5'h00, 5'(18 + i), 5'h00);
      want(3'h2);
      stat(6'h3f, ~(3'h1 << i), 3'h7);
      settle();
      want(3'h0);
      stat(6'h3f, 3'h7, 3'h1 << i);
      cfg(1'b0, 5'h00, 5'h00, 5'(24 + i));
      want(3'h3);
      stat(6'h3f, 3'h7, ~(3'h1 << i));
      settle();
      want(3'h0);
    end
    stat(6'h3f, 3'h7, 3'h7);
    cfg(1'b0, 5'h08, 5'h15, 5'h1b);
    want(3'h0);
  endtask
  task automatic test_packed;
    cfg(1'b1, 5'h02, 5'h12, 5'h18);
    chk({16'h0, packedMode}, 17'h00001);
    for (int c = 0; c < 8; c++) begin
      stat({5'h00, c[0]}, {2'h0, c[1]}, {2'h0, c[2]});
      settle();
      want(3'(c));
    end
  endtask
  task automatic test_midreset;
    // reset in mid-run from packed mode with preset seven active
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    rst_chk();
    for (int i = 1; i < 8; i++) begin
      pv[i] = CFS_FREQ_ZERO;
    end
    stat(6'h04, 3'h0, 3'h0);
    settle();
    want(3'h1);
    stat(6'h08, 3'h0, 3'h0);
    settle();
    want(3'h2);
  endtask
  initial begin
    pv[0] = CFS_FREQ_ZERO;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    rst_chk();
    test_presets();
    test_separate();
    test_routing();
    test_packed();
    test_midreset();
    stop_test();
  end
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule
